// ### hw/vtf_pkg.sv
// constants, field layout and types shared by the vlan framer files
package vtf_pkg;
  // port and table dimensions
  localparam int NPORT = 8;
  localparam int PW = 3;
  localparam int NVLAN = 255;
  localparam int VW = 12;
  // frame layout
  localparam logic [15:0] TPID = 16'h8100;
  localparam int HDR_BYTES = 16;
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [4:0] TAG_POS = 5'h0C;
  localparam logic [4:0] LEN_KEEP = 5'h10;
  localparam logic [4:0] LEN_INS = 5'h14;
  localparam logic [4:0] LEN_STRIP = 5'h0C;
  localparam logic [1:0] FCS_LAST = 2'h3;
  // factory defaults
  localparam logic [VW-1:0] BASE_VID = 12'h001;
  localparam logic [NPORT-1:0] ALL_PORTS = 8'hFF;
  // register byte addresses
  localparam logic [11:0] A_FWD_CNT = 12'h000;
  localparam logic [11:0] A_DROP_CNT = 12'h004;
  localparam logic [11:0] A_STATUS = 12'h008;
  localparam logic [11:0] A_PORT_BASE = 12'h100;
  localparam logic [11:0] A_PORT_END = 12'h11C;
  localparam logic [11:0] A_ENT_BASE = 12'h400;
  localparam logic [11:0] A_ENT_END = 12'h7F8;
  // port config fields
  localparam int PC_PVID_LSB = 0;
  localparam int PC_TAG_BIT = 12;
  localparam int PC_PRI_LSB = 13;
  // vlan entry fields
  localparam int VE_VID_LSB = 0;
  localparam int VE_MEM_LSB = 12;
  localparam int VE_VALID_BIT = 31;
  // crc-32, reflected
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  // address decode kinds
  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_FWD = 3'h1, K_DROP = 3'h2, K_STAT = 3'h3,
    K_PORT = 3'h4, K_ENT = 3'h5
  } vtf_kind_t;
  // frame engine states
  typedef enum logic [5:0] {
    ST_HDR = 6'h01, ST_DEC = 6'h02, ST_EMIT = 6'h04,
    ST_BODY = 6'h08, ST_FCS = 6'h10, ST_DROP = 6'h20
  } vtf_state_t;
endpackage

// ### hw/vtf_crc32.sv
// running ethernet crc-32 over a byte stream
`timescale 1ns/1ps
`default_nettype none
module vtf_crc32 (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // byte feed
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  // running remainder
  output logic [31:0] crc_r
);
  // one byte of the reflected crc, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (vtf_pkg::CRC_POLY & {32{r[0] ^ d[i]}});
    end
    return r;
  endfunction

  // init wins over a feed in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset || init) begin
      crc_r <= vtf_pkg::CRC_INIT;
    end else if (en) begin
      crc_r <= crc_byte(crc_r, data);
    end
  end
endmodule
`default_nettype wire

// ### hw/vtf_vlan_framer.sv
// vlan classify, egress filter and tag insert/strip framer with apb regs
`timescale 1ns/1ps
`default_nettype none
module vtf_vlan_framer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ingress byte stream, fcs already removed
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic [2:0] in_port,
  input wire logic [2:0] in_egress,
  output logic in_ready,
  // egress byte stream with new fcs
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_first,
  output logic out_last,
  output logic [2:0] out_port
);
  localparam int NP = vtf_pkg::NPORT;
  localparam int NV = vtf_pkg::NVLAN;
  localparam int VW = vtf_pkg::VW;

  vtf_pkg::vtf_state_t state_r, state_nxt;
  logic [7:0] hdr_r [vtf_pkg::HDR_BYTES];
  logic [4:0] cnt_r, hdr_len_r;
  logic [1:0] fcs_idx_r;
  logic [vtf_pkg::PW-1:0] ing_r, egr_r;
  logic ins_r, last_seen_r, in_ready_r;
  logic [15:0] tci_r;
  logic [VW-1:0] last_vid_r;
  logic [VW-1:0] pvid_r [NP];
  logic [NP-1:0] txtag_r;
  logic [2:0] pri_r [NP];
  logic [NV-1:0] ent_valid_r;
  logic [VW-1:0] ent_vid_r [NV];
  logic [NP-1:0] ent_mem_r [NV];
  logic [31:0] fwd_cnt_r, drop_cnt_r;
  logic [31:0] prdata_r, rd_w;
  logic pready_r, pslverr_r;
  logic out_valid_r, out_first_r, out_last_r;
  logic [7:0] out_data_r;
  logic [2:0] out_port_r;
  logic [31:0] crc_w;
  logic in_fire, tagged_w, hit_w, pass_w, runt_w;
  logic [VW-1:0] tag_vid_w, cls_vid_w;
  logic [NP-1:0] hit_mem_w, wmem_w;
  logic [7:0] emit_w, feed_w;
  logic feed_en_w;
  logic wr_w;
  vtf_pkg::vtf_kind_t kind_w;

  // register address decode, shared by read, write and error paths
  function automatic vtf_pkg::vtf_kind_t dec_kind(input logic [11:0] a);
    vtf_pkg::vtf_kind_t k;
    k = vtf_pkg::K_NONE;
    if (a[1:0] != 2'h0) begin
      k = vtf_pkg::K_NONE;
    end else if (a == vtf_pkg::A_FWD_CNT) begin
      k = vtf_pkg::K_FWD;
    end else if (a == vtf_pkg::A_DROP_CNT) begin
      k = vtf_pkg::K_DROP;
    end else if (a == vtf_pkg::A_STATUS) begin
      k = vtf_pkg::K_STAT;
    end else if (a >= vtf_pkg::A_PORT_BASE && a <= vtf_pkg::A_PORT_END) begin
      k = vtf_pkg::K_PORT;
    end else if (a >= vtf_pkg::A_ENT_BASE && a <= vtf_pkg::A_ENT_END) begin
      k = vtf_pkg::K_ENT;
    end
    return k;
  endfunction

  assign in_fire = in_valid && in_ready_r;
  assign kind_w = dec_kind(paddr);
  assign wr_w = psel && penable && pready_r && pwrite && !pslverr_r;
  assign wmem_w = pwdata[vtf_pkg::VE_MEM_LSB +: NP];
  assign runt_w = in_fire && in_last && cnt_r != vtf_pkg::HDR_LAST;

  // tag detection and field split of the buffered header
  assign tagged_w = {hdr_r[12], hdr_r[13]} == vtf_pkg::TPID;
  assign tag_vid_w = {hdr_r[14][3:0], hdr_r[15]};
  assign cls_vid_w = tagged_w ? tag_vid_w : pvid_r[ing_r];

  // vlan table lookup; egress must be a member of the classified vlan
  always_comb begin
    hit_w = 1'b0;
    hit_mem_w = '0;
    for (int e = 0; e < NV; e++) begin
      if (ent_valid_r[e] && ent_vid_r[e] == cls_vid_w) begin
        hit_w = 1'b1;
        hit_mem_w = hit_mem_w | ent_mem_r[e];
      end
    end
    pass_w = hit_w && hit_mem_w[egr_r];
  end

  // next frame state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      vtf_pkg::ST_HDR: begin
        if (in_fire && cnt_r == vtf_pkg::HDR_LAST) begin
          state_nxt = vtf_pkg::ST_DEC;
        end
      end
      vtf_pkg::ST_DEC: begin
        if (pass_w) begin
          state_nxt = vtf_pkg::ST_EMIT;
        end else if (!last_seen_r) begin
          state_nxt = vtf_pkg::ST_DROP;
        end else begin
          state_nxt = vtf_pkg::ST_HDR;
        end
      end
      vtf_pkg::ST_EMIT: begin
        if (cnt_r == hdr_len_r - 5'h01) begin
          state_nxt = last_seen_r ? vtf_pkg::ST_FCS : vtf_pkg::ST_BODY;
        end
      end
      vtf_pkg::ST_BODY: begin
        if (in_fire && in_last) begin
          state_nxt = vtf_pkg::ST_FCS;
        end
      end
      vtf_pkg::ST_FCS: begin
        if (fcs_idx_r == vtf_pkg::FCS_LAST) begin
          state_nxt = vtf_pkg::ST_HDR;
        end
      end
      vtf_pkg::ST_DROP: begin
        if (in_fire && in_last) begin
          state_nxt = vtf_pkg::ST_HDR;
        end
      end
      default: state_nxt = vtf_pkg::ST_HDR;
    endcase
  end

  // header byte to send: inserted tag sits after the source mac
  always_comb begin
    emit_w = hdr_r[cnt_r[3:0]];
    if (ins_r && cnt_r >= vtf_pkg::TAG_POS) begin
      if (cnt_r >= vtf_pkg::LEN_KEEP) begin
        emit_w = hdr_r[4'(cnt_r - 5'h04)];
      end else begin
        case (cnt_r[1:0])
          2'h0: emit_w = vtf_pkg::TPID[15:8];
          2'h1: emit_w = vtf_pkg::TPID[7:0];
          2'h2: emit_w = tci_r[15:8];
          default: emit_w = tci_r[7:0];
        endcase
      end
    end
  end

  // byte fed to crc is exactly the byte sent
  assign feed_w = (state_r == vtf_pkg::ST_EMIT) ? emit_w : in_data;
  assign feed_en_w = state_r == vtf_pkg::ST_EMIT ||
                     (state_r == vtf_pkg::ST_BODY && in_fire);

  vtf_crc32 u_crc (
    .ref_clk(ref_clk),
    .reset(reset),
    .init(state_r == vtf_pkg::ST_DEC),
    .en(feed_en_w),
    .data(feed_w),
    .crc_r(crc_w)
  );

  // state, input ready and header counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= vtf_pkg::ST_HDR;
      in_ready_r <= 1'b0;
      cnt_r <= 5'h00;
      fcs_idx_r <= 2'h0;
      last_seen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      in_ready_r <= state_nxt == vtf_pkg::ST_HDR ||
                    state_nxt == vtf_pkg::ST_BODY ||
                    state_nxt == vtf_pkg::ST_DROP;
      if (state_r == vtf_pkg::ST_HDR && in_fire) begin
        cnt_r <= runt_w ? 5'h00 : cnt_r + 5'h01;
        last_seen_r <= in_last;
      end else if (state_r == vtf_pkg::ST_DEC) begin
        cnt_r <= 5'h00;
      end else if (state_r == vtf_pkg::ST_EMIT) begin
        cnt_r <= cnt_r + 5'h01;
      end else if (state_r == vtf_pkg::ST_FCS) begin
        cnt_r <= 5'h00;
      end
      fcs_idx_r <= (state_r == vtf_pkg::ST_FCS) ? fcs_idx_r + 2'h1 : 2'h0;
    end
  end

  // header capture and per-frame tag decision
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < vtf_pkg::HDR_BYTES; i++) begin
        hdr_r[i] <= 8'h00;
      end
      ing_r <= '0;
      egr_r <= '0;
      ins_r <= 1'b0;
      hdr_len_r <= vtf_pkg::LEN_KEEP;
      tci_r <= 16'h0000;
      last_vid_r <= '0;
    end else if (state_r == vtf_pkg::ST_HDR && in_fire) begin
      hdr_r[cnt_r[3:0]] <= in_data;
      if (cnt_r == 5'h00) begin
        ing_r <= in_port;
        egr_r <= in_egress;
      end
    end else if (state_r == vtf_pkg::ST_DEC) begin
      last_vid_r <= cls_vid_w;
      tci_r <= {pri_r[ing_r], 1'b0, cls_vid_w};
      ins_r <= !tagged_w && txtag_r[egr_r];
      if (!tagged_w && txtag_r[egr_r]) begin
        hdr_len_r <= vtf_pkg::LEN_INS;
      end else if (tagged_w && !txtag_r[egr_r]) begin
        hdr_len_r <= vtf_pkg::LEN_STRIP;
      end else begin
        hdr_len_r <= vtf_pkg::LEN_KEEP;
      end
    end
  end

  // egress stream outputs; fcs bytes go out low byte first
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_valid_r <= 1'b0;
      out_data_r <= 8'h00;
      out_first_r <= 1'b0;
      out_last_r <= 1'b0;
      out_port_r <= 3'h0;
    end else begin
      out_valid_r <= feed_en_w || state_r == vtf_pkg::ST_FCS;
      out_first_r <= state_r == vtf_pkg::ST_EMIT && cnt_r == 5'h00;
      out_last_r <= state_r == vtf_pkg::ST_FCS &&
                    fcs_idx_r == vtf_pkg::FCS_LAST;
      out_port_r <= egr_r;
      if (state_r == vtf_pkg::ST_FCS) begin
        out_data_r <= ~crc_w[{fcs_idx_r, 3'b000} +: 8];
      end else if (feed_en_w) begin
        out_data_r <= feed_w;
      end
    end
  end

  // forwarded and dropped frame counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fwd_cnt_r <= 32'h00000000;
      drop_cnt_r <= 32'h00000000;
    end else if (state_r == vtf_pkg::ST_DEC) begin
      if (pass_w) begin
        fwd_cnt_r <= fwd_cnt_r + 32'h00000001;
      end else begin
        drop_cnt_r <= drop_cnt_r + 32'h00000001;
      end
    end else if (state_r == vtf_pkg::ST_HDR && runt_w) begin
      drop_cnt_r <= drop_cnt_r + 32'h00000001;
    end
  end

  // per-port pvid, transmit tagging and default priority
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int p = 0; p < NP; p++) begin
        pvid_r[p] <= vtf_pkg::BASE_VID;
        pri_r[p] <= 3'h0;
      end
      txtag_r <= '0;
    end else if (wr_w && kind_w == vtf_pkg::K_PORT) begin
      pvid_r[paddr[4:2]] <= pwdata[vtf_pkg::PC_PVID_LSB +: VW];
      txtag_r[paddr[4:2]] <= pwdata[vtf_pkg::PC_TAG_BIT];
      pri_r[paddr[4:2]] <= pwdata[vtf_pkg::PC_PRI_LSB +: 3];
    end
  end

  // vlan table; slot 0 is the factory base vlan
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int e = 0; e < NV; e++) begin
        ent_vid_r[e] <= '0;
        ent_mem_r[e] <= '0;
      end
      ent_valid_r <= '0;
      ent_valid_r[0] <= 1'b1;
      ent_vid_r[0] <= vtf_pkg::BASE_VID;
      ent_mem_r[0] <= vtf_pkg::ALL_PORTS;
    end else if (wr_w && kind_w == vtf_pkg::K_ENT) begin
      ent_vid_r[paddr[9:2]] <= pwdata[vtf_pkg::VE_VID_LSB +: VW];
      ent_mem_r[paddr[9:2]] <= wmem_w;
      ent_valid_r[paddr[9:2]] <= pwdata[vtf_pkg::VE_VALID_BIT];
      if (paddr[9:2] != 8'h00 && pwdata[vtf_pkg::VE_VALID_BIT]) begin
        ent_mem_r[0] <= ent_mem_r[0] & ~wmem_w;
      end
    end
  end

  // read mux
  always_comb begin
    rd_w = 32'h00000000;
    if (kind_w == vtf_pkg::K_FWD) begin
      rd_w = fwd_cnt_r;
    end else if (kind_w == vtf_pkg::K_DROP) begin
      rd_w = drop_cnt_r;
    end else if (kind_w == vtf_pkg::K_STAT) begin
      rd_w = {10'h000, state_r, 4'h0, last_vid_r};
    end else if (kind_w == vtf_pkg::K_PORT) begin
      rd_w = {16'h0000, pri_r[paddr[4:2]], txtag_r[paddr[4:2]],
              pvid_r[paddr[4:2]]};
    end else if (kind_w == vtf_pkg::K_ENT) begin
      rd_w = {ent_valid_r[paddr[9:2]], 11'h000, ent_mem_r[paddr[9:2]],
              ent_vid_r[paddr[9:2]]};
    end
  end

  // apb answer: ready in the first access cycle, no wait states
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && kind_w == vtf_pkg::K_NONE;
      if (psel && !penable && !pwrite) begin
        prdata_r <= rd_w;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
  assign out_first = out_first_r;
  assign out_last = out_last_r;
  assign out_port = out_port_r;

  // checks on the frame engine and table
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_tag_detect: assert property (
    state_r == vtf_pkg::ST_DEC && hdr_r[12] == 8'h81 && hdr_r[13] == 8'h00
    |-> tagged_w) else $error("tpid not detected");
  a_tag_vid_class: assert property (
    state_r == vtf_pkg::ST_DEC && tagged_w |=>
    last_vid_r == {$past(hdr_r[14][3:0]), $past(hdr_r[15])})
    else $error("tagged frame not classified by its vid");
  a_pvid_class: assert property (
    state_r == vtf_pkg::ST_DEC && !tagged_w |=>
    last_vid_r == $past(pvid_r[ing_r])) else $error("pvid not used");
  a_insert_tpid: assert property (
    state_r == vtf_pkg::ST_EMIT && ins_r && cnt_r == vtf_pkg::TAG_POS
    |=> out_data_r == 8'h81 ##1 out_data_r == 8'h00)
    else $error("inserted tpid wrong");
  a_len_adjust: assert property (
    state_r == vtf_pkg::ST_DEC && pass_w && !tagged_w && txtag_r[egr_r]
    |=> hdr_len_r == 5'h14) else $error("insert length not plus four");
  a_strip_len: assert property (
    state_r == vtf_pkg::ST_DEC && pass_w && tagged_w && !txtag_r[egr_r]
    |=> hdr_len_r == 5'h0C) else $error("strip length wrong");
  a_nonmember_drop: assert property (
    state_r == vtf_pkg::ST_DEC && !hit_mem_w[egr_r]
    |=> !out_valid_r [*2]) else $error("frame sent to non-member port");
  a_fcs_tail: assert property (
    state_r == vtf_pkg::ST_FCS && fcs_idx_r == 2'h0
    |=> out_valid_r [*4] ##1 $past(out_last_r))
    else $error("fcs not four bytes ending the frame");
  a_factory_base: assert property (
    $fell(reset) |-> ent_vid_r[0] == 12'h001 && pvid_r[3] == 12'h001 &&
    ent_mem_r[0] == 8'hFF && txtag_r == 8'h00)
    else $error("factory defaults wrong");
  a_base_prune: assert property (
    wr_w && kind_w == vtf_pkg::K_ENT && paddr[9:2] != 8'h00 && pwdata[31]
    |=> (ent_mem_r[0] & $past(wmem_w)) == 8'h00)
    else $error("base vlan kept a moved port");
  a_entry_cap: assert property (
    psel && !penable && paddr == 12'h7FC |=> pslverr_r)
    else $error("entry beyond table accepted");
endmodule
`default_nettype wire

// ### testbench/vtf_eth_sink.sv
// station model that takes the framer's egress byte stream
`timescale 1ns/1ps
`default_nettype none
module vtf_eth_sink (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // egress stream, no back-pressure
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_first,
  input wire logic out_last,
  input wire logic [2:0] out_port
);
  logic [7:0] rx_q[$];
  int frames;
  logic [2:0] port_seen;
  // restart on first byte, count frame on its last fcs byte
  always @(posedge ref_clk) begin
    if (reset) begin
      frames <= 0;
    end else if (out_valid === 1'h1) begin
      if (out_first === 1'h1) begin
        rx_q = {};
        port_seen <= out_port;
      end
      rx_q.push_back(out_data);
      if (out_last === 1'h1) begin
        frames <= frames + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_vlan_tag_classify_filter.sv
// register and frame tests of the vlan framer
`timescale 1ns/1ps
`default_nettype none
module tb_vlan_tag_classify_filter;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic in_valid, in_last, in_ready, out_valid, out_first, out_last;
  logic [7:0] in_data, out_data;
  logic [2:0] in_port, in_egress, out_port;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] bad_d;
  logic bad_e;
  vtf_vlan_framer dut_u (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
    .in_port(in_port), .in_egress(in_egress), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_first(out_first),
    .out_last(out_last), .out_port(out_port));
  vtf_eth_sink sink_u (.ref_clk(ref_clk), .reset(reset),
    .out_valid(out_valid), .out_data(out_data), .out_first(out_first),
    .out_last(out_last), .out_port(out_port));
  // 40 mhz clock
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // single comparison point
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checked++;
    if (seen !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'h1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // idle edge so a following call never reassigns psel in one step
    @(posedge ref_clk);
  endtask
  task wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'h1, a, d, x, e);
    chk("write err", {31'h0, e}, 32'h0);
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex,
             input logic ex_err);
    logic [31:0] d;
    logic e;
    apb(1'h0, a, 32'h0, d, e);
    chk(nm, d, ex);
    chk("read err", {31'h0, e}, {31'h0, ex_err});
  endtask
  // frame: two addresses, optional tag, type, ten payload bytes
  task mk(output logic [7:0] q[$], input logic tg, input logic [15:0] tci);
    q = {};
    for (int i = 0; i < 12; i++) q.push_back(8'h11 + 8'(i));
    if (tg) begin
      q.push_back(8'h81);
      q.push_back(8'h00);
      q.push_back(tci[15:8]);
      q.push_back(tci[7:0]);
    end
    q.push_back(8'h88);
    q.push_back(8'hB5);
    for (int i = 0; i < 10; i++) q.push_back(8'hA0 + 8'(i));
  endtask
  // reference crc-32, complemented, sent low byte first
  function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction
  // send one frame byte by byte under in_ready
  task send(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      in_valid <= 1'h1;
      in_data <= q[i];
      in_last <= (i == q.size() - 1);
      do begin
        @(posedge ref_clk);
      end while (in_ready !== 1'h1);
    end
    in_valid <= 1'h0;
    in_last <= 1'h0;
  endtask
  // send a frame and compare what the egress port sees
  task run(input logic [2:0] ip, input logic [2:0] eg, input logic tg,
           input logic [15:0] tci, input logic fwd, input logic xtg,
           input logic [15:0] xtci);
    int f0;
    int k;
    logic [7:0] fin[$];
    logic [7:0] fx[$];
    logic [31:0] c;
    f0 = sink_u.frames;
    mk(fin, tg, tci);
    in_port <= ip;
    in_egress <= eg;
    send(fin);
    k = 0;
    while (sink_u.frames == f0 && k < 80) begin
      @(posedge ref_clk);
      k++;
    end
    chk("frames", sink_u.frames, f0 + (fwd ? 1 : 0));
    if (fwd) begin
      mk(fx, xtg, xtci);
      c = crc_of(fx);
      for (int i = 0; i < 4; i++) fx.push_back(c[8*i +: 8]);
      chk("length", sink_u.rx_q.size(), fx.size());
      chk("port", {29'h0, sink_u.port_seen}, {29'h0, eg});
      foreach (fx[i]) begin
        if (i < sink_u.rx_q.size()) chk("byte", sink_u.rx_q[i], fx[i]);
      end
    end
  endtask
  // watchdog
  initial begin
    #(25ns * 20000);
    n_errors++;
    close_out();
  end
  // main sequence
  initial begin
    reset = 1'h1;
    {psel, penable, pwrite, in_valid, in_last} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    in_data = 8'h0;
    in_port = 3'h0;
    in_egress = 3'h0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rdchk("port0", vtf_pkg::A_PORT_BASE, 32'h00000001, 1'h0);
    rdchk("port7", vtf_pkg::A_PORT_END, 32'h00000001, 1'h0);
    rdchk("ent0", vtf_pkg::A_ENT_BASE, 32'h800FF001, 1'h0);
    rdchk("ent254", vtf_pkg::A_ENT_END, 32'h0, 1'h0);
    rdchk("ent255", 12'h7FC, 32'h0, 1'h1);
    run(3'h0, 3'h1, 1'h0, 16'h0, 1'h1, 1'h0, 16'h0);
    wr32(vtf_pkg::A_PORT_BASE, 32'h00006001);
    wr32(vtf_pkg::A_PORT_BASE + 12'h008, 32'h00001001);
    run(3'h0, 3'h2, 1'h0, 16'h0, 1'h1, 1'h1, 16'h6001);
    run(3'h1, 3'h1, 1'h1, 16'hE001, 1'h1, 1'h0, 16'h0);
    run(3'h1, 3'h2, 1'h1, 16'hE001, 1'h1, 1'h1, 16'hE001);
    wr32(vtf_pkg::A_ENT_BASE + 12'h004, 32'h8000C005);
    rdchk("ent0", vtf_pkg::A_ENT_BASE, 32'h800F3001, 1'h0);
    run(3'h0, 3'h3, 1'h1, 16'h2005, 1'h1, 1'h0, 16'h0);
    run(3'h0, 3'h1, 1'h1, 16'h2005, 1'h0, 1'h0, 16'h0);
    run(3'h4, 3'h2, 1'h1, 16'h0001, 1'h0, 1'h0, 16'h0);
    wr32(vtf_pkg::A_PORT_BASE + 12'h010, 32'h00000005);
    run(3'h4, 3'h3, 1'h0, 16'h0, 1'h1, 1'h0, 16'h0);
    run(3'h4, 3'h0, 1'h0, 16'h0, 1'h0, 1'h0, 16'h0);
    run(3'h0, 3'h1, 1'h1, 16'h0007, 1'h0, 1'h0, 16'h0);
    rdchk("fwd cnt", vtf_pkg::A_FWD_CNT, 32'h6, 1'h0);
    rdchk("drop cnt", vtf_pkg::A_DROP_CNT, 32'h4, 1'h0);
    rdchk("status", vtf_pkg::A_STATUS, 32'h00010007, 1'h0);
    apb(1'h1, vtf_pkg::A_PORT_BASE + 12'h001, 32'h00001FFF, bad_d, bad_e);
    chk("bad write err", {31'h0, bad_e}, 32'h1);
    rdchk("port0 kept", vtf_pkg::A_PORT_BASE, 32'h00006001, 1'h0);
    close_out();
  end
endmodule
`default_nettype wire
